/* inc/dcm_consts.svh */
// Purpose: Constants for the disk address to card sector mapper
// Assumes: Included by bare name; definitions only
// Notes:   Offsets and geometry are `define macros
`ifndef DCM_CONSTS_SVH
`define DCM_CONSTS_SVH

// ****************************************************************
// Card and sector layout
// ****************************************************************
`define DCM_CARD_SECTOR_BYTES   512
`define DCM_WORDS_PER_SECTOR    128
`define DCM_BYTES_PER_WORD      8
`define DCM_DATA_BITS           36
`define DCM_SLOT_BITS           64
`define DCM_CARD_PER_EMU        2
`define DCM_DRIVES              8
`define DCM_DRIVE_STRIDE        2097152
`define DCM_DRIVE_SHIFT         21

// ****************************************************************
// Drive geometries
// ****************************************************************
`define DCM_SMALL_HEADS         19
`define DCM_SMALL_SECTORS       20
`define DCM_SMALL_CYLS          815
`define DCM_LARGE_HEADS         32
`define DCM_LARGE_SECTORS       43
`define DCM_LARGE_CYLS          630
`define DCM_DIAG_SECTORS        22

`endif

/* inc/dcm_pkg.sv */
// Purpose: Types for the disk address to card sector mapper
// Assumes: Constants live in dcm_consts.svh
// Notes:   Holds state and geometry enumerations
package dcm_pkg;

	// Translation sequencer states
	typedef enum logic [2:0]
	{
		DCM_IDLE = 3'b000,
		DCM_CYL  = 3'b001,
		DCM_TRK  = 3'b010,
		DCM_SEC  = 3'b011,
		DCM_DONE = 3'b100
	} dcm_state_t;

	// Drive geometry selection
	typedef enum logic
	{
		DCM_GEOM_SMALL = 1'b0,
		DCM_GEOM_LARGE = 1'b1
	} dcm_geom_t;

endpackage

/* design/dcm_word_pack.sv */
// Purpose: Packs one data word into an eight byte card slot
// Assumes: Combinational helper used by the mapper
// Notes:   Low byte first, upper bits forced to zero
`timescale 1ns/10ps
`default_nettype none
`include "dcm_consts.svh"

module dcm_word_pack
	import dcm_pkg::*;
(
	input  wire logic [`DCM_DATA_BITS-1:0] i_word,
	input  wire logic                      i_fill_zero,
	output logic      [`DCM_SLOT_BITS-1:0] o_slot
);

	logic [`DCM_SLOT_BITS-1:0] wide;

	// Zero fill past the end of a short write
	// zero fill
	assign wide = i_fill_zero ? '0 : {{(`DCM_SLOT_BITS-`DCM_DATA_BITS){1'b0}}, i_word};

	// Byte 0 goes out first, so it sits in the low lane
	// byte order
	genvar b;
	generate
		for (b = 0; b < `DCM_BYTES_PER_WORD; b++)
		begin : g_lane
			assign o_slot[b*8 +: 8] = wide[b*8 +: 8];
		end
	endgenerate

endmodule // dcm_word_pack

`default_nettype wire

/* design/dcm_mapper.sv */
// Purpose: Maps cylinder, track, sector to a linear card sector
// Assumes: One 10 MHz clock, synchronous active low reset
// Notes:   Multiplies by repeated addition; also steps the address
// Functional notes
// - Card access always covers whole 512-byte sectors.
// - Every access carries a 32-bit linear sector address.
// - Cylinder from desired cylinder, track and sector from sector/track.
// - Address is ((cyl*heads+track)*sectors+sector) times two.
// - Multiplications done by repeated addition over many cycles.
// - Small drive uses 19 heads and 20 sectors per track.
// - Emulated sector is 128 words of 8 bytes, 1024 bytes.
// - After a transfer sector and track advance with wraparound; cylinder just increments.
// - Short write pads rest of sector with zeros.
// - Short read delivers only the requested words.
// - Each 36-bit word sits in a 64-bit slot, upper zero.
// - Slot bytes ordered least significant first.
// - Each of 8 drives starts on a fixed 1 GB boundary.
// - Data uses the 20-sector format only; 22 is diagnostic.
// - Small drive has 815 cylinders; geometry stays configurable.
// - Large drive uses 43 sectors, 32 tracks, 630 cylinders.
`timescale 1ns/10ps
`default_nettype none
`include "dcm_consts.svh"

module dcm_mapper
	import dcm_pkg::*;
#(
	parameter int CYL_W  = 10,
	parameter int TRK_W  = 6,
	parameter int SEC_W  = 6,
	parameter int WIDX_W = 7
)
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_start,
	input  wire logic                      i_geom,
	input  wire logic [2:0]                i_drive,
	input  wire logic [CYL_W-1:0]          desired_cylinder_reg,
	input  wire logic [15:0]               sector_track_reg,
	input  wire logic                      i_advance,
	input  wire logic                      i_load,
	input  wire logic [WIDX_W:0]           i_req_words,
	input  wire logic                      i_wr_valid,
	input  wire logic [`DCM_DATA_BITS-1:0] i_wr_word,
	input  wire logic                      i_rd_valid,
	input  wire logic [`DCM_SLOT_BITS-1:0] i_rd_slot,
	output logic                           o_busy,
	output logic                           o_done,
	output logic [31:0]                    o_sd_addr,
	output logic [1:0]                     o_sd_count,
	output logic [CYL_W-1:0]               o_cyl,
	output logic [TRK_W-1:0]               o_trk,
	output logic [SEC_W-1:0]               o_sec,
	output logic                           o_wr_slot_valid,
	output logic [`DCM_SLOT_BITS-1:0]      o_wr_slot,
	output logic                           o_wr_last,
	output logic                           o_mem_valid,
	output logic [`DCM_DATA_BITS-1:0]      o_mem_word,
	output logic                           o_fmt_err
);

	// ****************************************************************
	// Geometry selection
	// ****************************************************************
	localparam logic [TRK_W-1:0] SMALL_HEADS = TRK_W'(`DCM_SMALL_HEADS);
	localparam logic [SEC_W-1:0] SMALL_SECS  = SEC_W'(`DCM_SMALL_SECTORS);
	localparam logic [CYL_W-1:0] SMALL_CYLS  = CYL_W'(`DCM_SMALL_CYLS);
	localparam logic [TRK_W-1:0] LARGE_HEADS = TRK_W'(`DCM_LARGE_HEADS);
	localparam logic [SEC_W-1:0] LARGE_SECS  = SEC_W'(`DCM_LARGE_SECTORS);
	localparam logic [CYL_W-1:0] LARGE_CYLS  = CYL_W'(`DCM_LARGE_CYLS);
	localparam logic [SEC_W-1:0] DIAG_SECS   = SEC_W'(`DCM_DIAG_SECTORS);
	localparam logic [WIDX_W:0]  FULL_WORDS  = (WIDX_W+1)'(`DCM_WORDS_PER_SECTOR);

	logic [TRK_W-1:0] heads;
	logic [SEC_W-1:0] spt;
	logic [CYL_W-1:0] ncyl;
	dcm_geom_t        geom_reg;

	always_comb
	begin
		if (geom_reg == DCM_GEOM_LARGE)
		begin
			heads = LARGE_HEADS;
			spt   = LARGE_SECS;
			ncyl  = LARGE_CYLS;
		end
		else
		begin
			heads = SMALL_HEADS;
			spt   = SMALL_SECS;
			ncyl  = SMALL_CYLS;
		end
	end

	// ****************************************************************
	// Disk address registers
	// ****************************************************************
	logic [CYL_W-1:0] cyl_reg;
	logic [TRK_W-1:0] trk_reg;
	logic [SEC_W-1:0] sec_reg;
	logic [2:0]       drive_reg;
	dcm_state_t       state_reg;

	// Latch inputs on load; step after a transfer
	// address sources
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			cyl_reg   <= '0;
			trk_reg   <= '0;
			sec_reg   <= '0;
			drive_reg <= '0;
			geom_reg  <= DCM_GEOM_SMALL;
		end
		else if (i_load && state_reg == DCM_IDLE)
		begin
			cyl_reg   <= desired_cylinder_reg;
			trk_reg   <= sector_track_reg[8 +: TRK_W];
			sec_reg   <= sector_track_reg[0 +: SEC_W];
			drive_reg <= i_drive;
			geom_reg  <= dcm_geom_t'(i_geom);
		end
		else if (i_advance && state_reg == DCM_IDLE)
		begin
			if (sec_reg == spt - 1'b1)
			begin
				sec_reg <= '0;
				if (trk_reg == heads - 1'b1)
				begin
					trk_reg <= '0;
					cyl_reg <= cyl_reg + 1'b1;
				end
				else
					trk_reg <= trk_reg + 1'b1;
			end
			else
				sec_reg <= sec_reg + 1'b1;
		end
	end

	// Flag addresses outside the data format; 22-sector is diagnostic only
	// data format check
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_fmt_err <= 1'b0;
		else if (i_start && state_reg == DCM_IDLE)
			o_fmt_err <= (sec_reg >= spt) || (trk_reg >= heads) || (cyl_reg >= ncyl)
				|| (geom_reg == DCM_GEOM_SMALL && sec_reg >= DIAG_SECS);
	end

	// ****************************************************************
	// Translation by repeated addition
	// ****************************************************************
	logic [31:0]      acc_reg;
	logic [CYL_W-1:0] cnt_reg;

	// Slow but tiny; disk timing leaves many idle cycles
	// repeated addition
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state_reg <= DCM_IDLE;
			acc_reg   <= '0;
			cnt_reg   <= '0;
		end
		else
		begin
			case (state_reg)
				DCM_IDLE:
				begin
					if (i_start)
					begin
						acc_reg   <= '0;
						cnt_reg   <= '0;
						state_reg <= DCM_CYL;
					end
				end
				DCM_CYL:
				begin
					// cyl * heads: add cyl once per head
					if (cnt_reg == CYL_W'(heads))
					begin
						acc_reg   <= acc_reg + 32'(trk_reg);
						cnt_reg   <= '0;
						state_reg <= DCM_TRK;
					end
					else
					begin
						acc_reg <= acc_reg + 32'(cyl_reg);
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				DCM_TRK:
				begin
					// (cyl*heads+trk) * spt: keep a running sum in prod_reg
					if (cnt_reg == CYL_W'(spt))
					begin
						state_reg <= DCM_SEC;
					end
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				DCM_SEC:
					state_reg <= DCM_DONE;
				DCM_DONE:
					state_reg <= DCM_IDLE;
				default:
					state_reg <= DCM_IDLE;
			endcase
		end
	end

	// Product accumulator for the sectors-per-track pass
	logic [31:0] prod_reg;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			prod_reg <= '0;
		else if (state_reg == DCM_CYL)
			prod_reg <= '0;
		else if (state_reg == DCM_TRK && cnt_reg != CYL_W'(spt))
			prod_reg <= prod_reg + acc_reg;
		else if (state_reg == DCM_SEC)
			prod_reg <= prod_reg + 32'(sec_reg);
	end

	// Output address: doubled, plus drive base on a 1 GB boundary
	// 32-bit address
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_sd_addr <= '0;
		else if (state_reg == DCM_DONE)
			o_sd_addr <= {prod_reg[30:0], 1'b0}
				+ {8'h00, drive_reg, `DCM_DRIVE_SHIFT'(0)};
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_busy <= (state_reg == DCM_IDLE) ? i_start : (state_reg != DCM_DONE);
			o_done <= (state_reg == DCM_DONE);
		end
	end

	// Two whole card sectors per emulated sector, never a partial one
	// whole card sectors
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_sd_count <= '0;
		else
			o_sd_count <= 2'(`DCM_CARD_PER_EMU);
	end

	// Mirror of the stepped address for the drive's own registers
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_cyl <= '0;
			o_trk <= '0;
			o_sec <= '0;
		end
		else
		begin
			o_cyl <= cyl_reg;
			o_trk <= trk_reg;
			o_sec <= sec_reg;
		end
	end

	// ****************************************************************
	// Word stream to and from the card
	// ****************************************************************
	logic [WIDX_W:0]          widx_reg;
	logic [WIDX_W:0]          ridx_reg;
	logic                     fill;
	logic [`DCM_SLOT_BITS-1:0] slot;

	// Past the requested count, slots are zero
	// zero fill
	assign fill = (widx_reg >= i_req_words);

	dcm_word_pack u_pack
	(
		.i_word      (i_wr_word),
		.i_fill_zero (fill),
		.o_slot      (slot)
	);

	// Padding slots go out without waiting for source words
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			widx_reg        <= '0;
			o_wr_slot_valid <= 1'b0;
			o_wr_slot       <= '0;
			o_wr_last       <= 1'b0;
		end
		else
		begin
			o_wr_slot_valid <= 1'b0;
			o_wr_last       <= 1'b0;
			if (i_start)
				widx_reg <= '0;
			else if ((i_wr_valid || fill) && widx_reg < FULL_WORDS && i_req_words != '0)
			begin
				o_wr_slot_valid <= 1'b1;
				o_wr_slot       <= slot;
				o_wr_last       <= (widx_reg == FULL_WORDS - 1'b1);
				widx_reg        <= widx_reg + 1'b1;
			end
		end
	end

	// Whole sector is read; only requested words reach memory
	// short read
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			ridx_reg    <= '0;
			o_mem_valid <= 1'b0;
			o_mem_word  <= '0;
		end
		else
		begin
			o_mem_valid <= 1'b0;
			if (i_start)
				ridx_reg <= '0;
			else if (i_rd_valid && ridx_reg < FULL_WORDS)
			begin
				ridx_reg    <= ridx_reg + 1'b1;
				o_mem_valid <= (ridx_reg < i_req_words);
				o_mem_word  <= i_rd_slot[`DCM_DATA_BITS-1:0];
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_run;
		state_reg == DCM_DONE;
	endsequence

	done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_done |=> !o_done)
		else $error("done longer than one cycle");

	done_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_run |=> o_done)
		else $error("done missing after translation");

	addr_even_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_done |-> o_sd_addr[0] == 1'b0)
		else $error("card address not even");

	drive_base_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_done |-> o_sd_addr[23:21] == drive_reg)
		else $error("drive base wrong");

	sec_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_advance && !i_load && state_reg == DCM_IDLE && sec_reg == spt - 1'b1)
		|=> sec_reg == '0)
		else $error("sector did not wrap");

	sec_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_advance && !i_load && state_reg == DCM_IDLE && sec_reg != spt - 1'b1)
		|=> sec_reg == $past(sec_reg) + 1'b1)
		else $error("sector did not step");

	slot_upper_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_wr_slot_valid |-> o_wr_slot[63:36] == '0)
		else $error("slot upper bits not zero");

	fill_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_wr_slot_valid && $past(fill)) |-> o_wr_slot == '0)
		else $error("padding slot not zero");

	short_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_rd_valid && ridx_reg >= i_req_words && !i_start) |=> !o_mem_valid)
		else $error("extra word sent to memory");

	count_whole_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_done |-> o_sd_count == 2'd2)
		else $error("partial card request");

endmodule // dcm_mapper

`default_nettype wire

/* verification/dcm_card_model.sv */
// Purpose: Behavioural card controller facing the mapper
// Assumes: Slots move as single cycle strobes, last slot marked
// Notes:   Read line shows inverted data between strobes
`timescale 1ns/10ps
`default_nettype none

module dcm_card_model
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_done,
	input  wire logic        i_wr_slot_valid,
	input  wire logic [63:0] i_wr_slot,
	input  wire logic        i_wr_last,
	output logic             o_rd_valid,
	output logic [63:0]      o_rd_slot
);
	logic [63:0] slot_mem [0:255];
	int          wr_cnt;
	int          last_idx;

	// Idle read line before the first frame
	initial
	begin
		o_rd_valid = 1'b0;
		o_rd_slot  = 64'h5a5a_5a5a_5a5a_5a5a;
	end

	// Capture write slots; counts run past 128 to expose overruns
	always @(posedge i_clk)
	begin
		if (i_rst_n !== 1'b1 || i_done === 1'b1)
		begin
			wr_cnt   <= 0;
			last_idx <= -1;
		end
		else if (i_wr_slot_valid === 1'b1)
		begin
			slot_mem[wr_cnt[7:0]] <= i_wr_slot;
			wr_cnt                <= wr_cnt + 1;
			if (i_wr_last === 1'b1)
				last_idx <= wr_cnt;
		end
	end

	// One card sector pair of slots; gap idles between slots when slow
	task automatic send_sector(input int gap);
		for (int i = 0; i < 128; i++)
		begin
			@(negedge i_clk);
			o_rd_valid = 1'b1;
			o_rd_slot  = {28'h000_0000, 36'h9_0000_0000 + 36'(i)};
			if (gap > 0)
			begin
				@(negedge i_clk);
				o_rd_valid = 1'b0;
				o_rd_slot  = ~o_rd_slot;
				repeat (gap - 1) @(negedge i_clk);
			end
		end
		@(negedge i_clk);
		o_rd_valid = 1'b0;
		o_rd_slot  = ~o_rd_slot;
	endtask
endmodule // dcm_card_model

`default_nettype wire

/* verification/disk_chs_to_sd_sector_mapper_tb_top.sv */
// Purpose: Self-checking bench for the card sector mapper
// Assumes: Card model stands in for the card controller
// Notes:   Inputs change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
`include "dcm_consts.svh"

module disk_chs_to_sd_sector_mapper_tb_top;
	logic        i_clk, i_rst_n, i_start, i_geom, i_advance, i_load;
	logic        i_wr_valid, i_rd_valid, o_busy, o_done, o_fmt_err;
	logic        o_wr_slot_valid, o_wr_last, o_mem_valid;
	logic [2:0]  i_drive;
	logic [9:0]  desired_cylinder_reg, o_cyl;
	logic [15:0] sector_track_reg;
	logic [7:0]  i_req_words;
	logic [35:0] i_wr_word, o_mem_word;
	logic [63:0] i_rd_slot, o_wr_slot;
	logic [31:0] o_sd_addr;
	logic [1:0]  o_sd_count;
	logic [5:0]  o_trk, o_sec;
	logic [35:0] mem_q[$];
	int          err_total;
	int          num_checks;

	// ****************************************
	// Design, partner and clock
	// ****************************************
	dcm_mapper uut
	(
		.i_clk, .i_rst_n, .i_start, .i_geom, .i_drive,
		.desired_cylinder_reg, .sector_track_reg, .i_advance, .i_load,
		.i_req_words, .i_wr_valid, .i_wr_word, .i_rd_valid, .i_rd_slot,
		.o_busy, .o_done, .o_sd_addr, .o_sd_count, .o_cyl, .o_trk, .o_sec,
		.o_wr_slot_valid, .o_wr_slot, .o_wr_last, .o_mem_valid,
		.o_mem_word, .o_fmt_err
	);

	dcm_card_model card
	(
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_done(o_done),
		.i_wr_slot_valid(o_wr_slot_valid), .i_wr_slot(o_wr_slot),
		.i_wr_last(o_wr_last), .o_rd_valid(i_rd_valid), .o_rd_slot(i_rd_slot)
	);

	// 10 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// Words handed to memory
	always @(posedge i_clk)
		if (o_mem_valid === 1'b1)
			mem_q.push_back(o_mem_word);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask

	// Latch a disk address while idle
	task automatic load(input int g, input int d, input int c, input int t, input int s);
		@(negedge i_clk);
		i_geom               = 1'(g);
		i_drive              = 3'(d);
		desired_cylinder_reg = 10'(c);
		sector_track_reg     = {2'b00, 6'(t), 2'b00, 6'(s)};
		i_load               = 1'b1;
		@(negedge i_clk);
		i_load = 1'b0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Translate one address; busy must hold until the done pulse
	task automatic xlate(input int g, input int d, input int c, input int t,
		input int s, input int ef);
		int     h;
		int     n;
		int     k;
		longint e;
		h = g ? `DCM_LARGE_HEADS : `DCM_SMALL_HEADS;
		n = g ? `DCM_LARGE_SECTORS : `DCM_SMALL_SECTORS;
		e = 2 * ((c * h + t) * n + s) + (longint'(d) << 21);
		load(g, d, c, t, s);
		i_start = 1'b1;
		@(negedge i_clk);
		i_start = 1'b0;
		for (k = 1; k < 300 && o_done !== 1'b1; k++)
		begin
			if (k > 1)
				chk("busy", 1, o_busy);
			@(negedge i_clk);
		end
		chk("done", 1, o_done);
		chk("latency", 1, k > h);
		if (ef == 0)
			chk("sd_addr", e[31:0], o_sd_addr);
		chk("fmt_err", ef, o_fmt_err);
		chk("count", 2, o_sd_count);
		@(negedge i_clk);
		chk("done_low", 0, o_done);
		chk("busy_low", 0, o_busy);
	endtask

	// Step the address once and look at the new position
	task automatic adv(input int g, input int c, input int t, input int s,
		input int ec, input int et, input int es);
		load(g, 0, c, t, s);
		i_advance = 1'b1;
		@(negedge i_clk);
		i_advance = 1'b0;
		repeat (2) @(negedge i_clk);
		chk("cyl", ec, o_cyl);
		chk("trk", et, o_trk);
		chk("sec", es, o_sec);
	endtask

	// Short or full write; the rest of the sector must be zero slots
	task automatic wr(input int n);
		i_req_words = 8'(n);
		xlate(0, 1, 2, 3, 4, 0);
		for (int i = 0; i < n; i++)
		begin
			i_wr_valid = 1'b1;
			i_wr_word  = 36'h8_0000_0000 + 36'(i);
			@(negedge i_clk);
		end
		i_wr_valid = 1'b0;
		i_wr_word  = ~i_wr_word;
		for (int k = 0; k < 600 && card.last_idx < 0; k++)
			@(negedge i_clk);
		chk("slots", 128, card.wr_cnt);
		chk("last", 127, card.last_idx);
		for (int i = 0; i < 128; i++)
			chk("slot", i < n ? 64'h8_0000_0000 + 64'(i) : 64'h0, card.slot_mem[i]);
	endtask

	// Whole sector read from the card; only requested words go on
	task automatic rd(input int n, input int gap);
		i_req_words = 8'(n);
		xlate(1, 2, 3, 4, 5, 0);
		mem_q.delete();
		card.send_sector(gap);
		repeat (10) @(negedge i_clk);
		chk("words", n, mem_q.size());
		foreach (mem_q[i])
			chk("word", 36'h9_0000_0000 + 36'(i), mem_q[i]);
	endtask

	// Reset in mid-run clears the address; count returns one edge after release
	task automatic rst_chk;
		load(0, 4, 100, 5, 6);
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		chk("rst_cyl", 0, o_cyl);
		chk("rst_count", 0, o_sd_count);
		chk("rst_done", 0, o_done);
		i_rst_n = 1'b1;
		@(negedge i_clk);
		chk("rel_count", 2, o_sd_count);
		chk("rel_sec", 0, o_sec);
		xlate(0, 6, 1, 2, 3, 0);
	endtask

	// Hang guard, well beyond the roughly 1500 cycles the run needs
	initial
	begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		err_total            = 0;
		num_checks           = 0;
		i_rst_n              = 1'b0;
		i_start              = 1'b0;
		i_geom               = 1'b0;
		i_drive              = 3'h0;
		desired_cylinder_reg = 10'h000;
		sector_track_reg     = 16'h0000;
		i_advance            = 1'b0;
		i_load               = 1'b0;
		i_req_words          = 8'h80;
		i_wr_valid           = 1'b0;
		i_wr_word            = 36'h0_0000_0000;
		repeat (20) @(negedge i_clk);
		i_rst_n = 1'b1;
		@(negedge i_clk);
		xlate(0, 7, 814, 18, 19, 0);
		xlate(1, 3, 629, 31, 42, 0);
		xlate(0, 0, 0, 0, 0, 0);
		xlate(0, 5, 10, 2, 22, 1);
		xlate(0, 1, 815, 0, 0, 1);
		xlate(1, 2, 0, 32, 0, 1);
		adv(0, 5, 18, 19, 6, 0, 0);
		adv(0, 5, 3, 19, 5, 4, 0);
		adv(0, 5, 3, 7, 5, 3, 8);
		adv(1, 9, 31, 42, 10, 0, 0);
		wr(3);
		wr(128);
		rd(4, 0);
		rd(128, 2);
		rst_chk();
		stop_test();
	end
endmodule // disk_chs_to_sd_sector_mapper_tb_top

`default_nettype wire
